// file: src/scsc_regs.svh
`ifndef SCSC_REGS_SVH
`define SCSC_REGS_SVH
// register byte addresses
`define SCSC_REQ_SEL_ADDR 12'h000
`define SCSC_CUR_SEL_ADDR 12'h004
`define SCSC_SWITCH_ADDR 12'h008
`define SCSC_READY_ADDR 12'h00C
`define SCSC_FORCE_ADDR 12'h010
`define SCSC_FREQ_ADDR 12'h014
`define SCSC_TRIM_ADDR 12'h018
`define SCSC_EVENT_ADDR 12'h01C
// source codes
`define SCSC_SRC_EXT 3'h7
`define SCSC_SRC_FAST1M 3'h6
`define SCSC_SRC_SLOW 3'h4
`define SCSC_SRC_SEC 3'h3
`define SCSC_SRC_EXT_PLL 3'h1
`define SCSC_SRC_FAST_PLL 3'h0
// field positions
`define SCSC_HOLD_BIT 7
`define SCSC_PWR_BIT 6
`define SCSC_BYP_BIT 5
`define SCSC_DONE_BIT 4
`define SCSC_TRDY_BIT 3
`define SCSC_RDY_EXT_BIT 7
`define SCSC_RDY_FAST_BIT 6
`define SCSC_RDY_SLOW_BIT 4
`define SCSC_RDY_SEC_BIT 3
`define SCSC_RDY_ADC_BIT 2
`define SCSC_RDY_PLL_BIT 0
// limits and reset values
`define SCSC_DIV_MAX 4'h9
`define SCSC_FREQ_RST_1M 3'h2
`define SCSC_FREQ_RST_32M 3'h6
`define SCSC_FREQ_RESERVED 3'h2
`define SCSC_DIV_RST_1M 4'h2
`define SCSC_DIV_RST_OTHER 4'h0
`define SCSC_TRIM_RST 6'h00
`define SCSC_PLL_LOCK_CYC 4'h8
`endif

// file: src/scsc_pkg.sv
package scsc_pkg;
  typedef logic [2:0] scsc_src_t;
  typedef logic [3:0] scsc_div_t;
  typedef struct packed {
    scsc_src_t src;
    scsc_div_t div;
  } scsc_sel_s;
  typedef struct packed {
    logic ext;
    logic fast;
    logic slow;
    logic sec;
    logic adc;
  } scsc_osc_s;
  typedef enum logic [1:0] {SCSC_IDLE, SCSC_WAIT, SCSC_HELD} scsc_sw_e;
endpackage : scsc_pkg

// file: src/scsc_postdiv.sv
`timescale 1ns/1ps
// post-divider: one-cycle enable every 2**ratio_log2 source ticks
module scsc_postdiv
  import scsc_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic src_tick, // selected source tick
  input wire scsc_div_t ratio_log2, // current divider code
  output logic sys_tick // divided system clock enable
);
  logic [8:0] cnt_q;
  logic [8:0] lim;

  assign lim = 9'(( 10'h001 << ratio_log2) - 10'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 9'h000;
    end else if (src_tick) begin
      cnt_q <= (cnt_q >= lim) ? 9'h000 : cnt_q + 9'h001;
    end
  end

  assign sys_tick = src_tick && (cnt_q >= lim);
endmodule : scsc_postdiv

// file: src/scsc_top.sv
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "scsc_regs.svh"
module scsc_top
  import scsc_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [2:0] reset_source_fuse, // reset source fuse
  input wire logic [2:0] external_mode_fuse, // external mode fuse
  input wire logic switch_enable_fuse, // switching allowed fuse
  input wire logic [4:0] osc_tick_raw, // ext,fast,slow,sec,adc ticks from pins
  input wire logic [4:0] osc_ready_raw, // ext,fast,slow,sec,adc ready from analog
  input wire logic pll_lock_raw, // pll lock from analog
  input wire logic [4:0] osc_other_req, // other-module oscillator requests
  input wire logic switch_irq_enable, // switch interrupt enable
  output logic [4:0] osc_enable, // ext,fast,slow,sec,adc enables
  output logic pll_enable, // pll enable
  output logic [2:0] pll_input_sel, // pll input source code
  output logic [2:0] ext_osc_mode, // external oscillator mode
  output logic [2:0] fast_internal_freq_sel, // fast osc frequency code
  output logic [5:0] fast_internal_trim, // fast osc trim
  output logic sec_osc_high_power, // secondary high power
  output logic sec_osc_in_schmitt, // secondary input as buffered clock
  output logic sec_osc_out_enable, // secondary output pin driven by crystal amp
  output logic sys_clk_en, // system clock enable pulse
  output logic switch_event_flag, // clock switch event flag
  output logic switch_irq // clock switch interrupt request
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for analog status and oscillator ticks
  logic [5:0] rdy_s1_q;
  logic [5:0] rdy_s2_q;
  logic [4:0] tick_s1_q;
  logic [4:0] tick_s2_q;
  logic [4:0] tick_s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_s1_q <= 6'h00;
      rdy_s2_q <= 6'h00;
    end else begin
      rdy_s1_q <= {pll_lock_raw, osc_ready_raw};
      rdy_s2_q <= rdy_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_s1_q <= 5'h00;
      tick_s2_q <= 5'h00;
      tick_s3_q <= 5'h00;
    end else begin
      tick_s1_q <= osc_tick_raw;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fuse capture after reset release
  logic fuse_taken_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_taken_q <= 1'b0;
    end else if (!fuse_taken_q) begin
      fuse_taken_q <= 1'b1;
    end
  end

  assign ext_osc_mode = external_mode_fuse;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  scsc_sel_s req_q;
  scsc_sel_s cur_q;
  logic hold_q;
  logic pwr_q;
  logic byp_q;
  logic trdy_q;
  logic [4:0] force_q;
  logic [2:0] freq_q;
  logic [5:0] trim_q;
  logic evt_q;
  scsc_sw_e sw_q;
  logic wr_en;
  logic do_switch;
  logic target_rdy;
  logic [3:0] wr_div;
  logic [2:0] wr_src;

  assign wr_en = psel && penable && pwrite;
  assign wr_div = (pwdata[3:0] > `SCSC_DIV_MAX) ? req_q.div : pwdata[3:0];
  assign wr_src = pwdata[6:4];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= '0;
    end else if (!fuse_taken_q) begin
      req_q.src <= reset_source_fuse;
      req_q.div <= (reset_source_fuse == `SCSC_SRC_FAST1M) ? `SCSC_DIV_RST_1M : `SCSC_DIV_RST_OTHER;
    end else if (wr_en && paddr == `SCSC_REQ_SEL_ADDR && switch_enable_fuse) begin
      req_q.src <= wr_src;
      req_q.div <= wr_div;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= '0;
    end else if (!fuse_taken_q) begin
      cur_q.src <= reset_source_fuse;
      cur_q.div <= (reset_source_fuse == `SCSC_SRC_FAST1M) ? `SCSC_DIV_RST_1M : `SCSC_DIV_RST_OTHER;
    end else if (do_switch) begin
      cur_q <= req_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
      pwr_q <= 1'b0;
      byp_q <= 1'b0;
    end else if (wr_en && paddr == `SCSC_SWITCH_ADDR) begin
      hold_q <= pwdata[`SCSC_HOLD_BIT];
      pwr_q <= pwdata[`SCSC_PWR_BIT];
      byp_q <= pwdata[`SCSC_BYP_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_q <= 5'h00;
      trim_q <= `SCSC_TRIM_RST;
    end else begin
      if (wr_en && paddr == `SCSC_FORCE_ADDR) begin
        force_q <= {pwdata[7:6], pwdata[4:2]};
      end
      if (wr_en && paddr == `SCSC_TRIM_ADDR) begin
        trim_q <= pwdata[5:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_q <= `SCSC_FREQ_RST_1M;
    end else if (!fuse_taken_q) begin
      freq_q <= (reset_source_fuse == `SCSC_SRC_FAST_PLL) ? `SCSC_FREQ_RST_32M : `SCSC_FREQ_RST_1M;
    end else if (wr_en && paddr == `SCSC_FREQ_ADDR) begin
      freq_q <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source decode
  function automatic logic [2:0] eff_src(input logic [2:0] code);
    logic [2:0] r;
    r = code;
    if (code == 3'h5 || code == 3'h2) begin
      r = `SCSC_SRC_FAST1M;
    end
    return r;
  endfunction : eff_src

  // index into {ext,fast,slow,sec,adc} vectors: 4=ext .. 0=adc
  function automatic logic [2:0] osc_idx(input logic [2:0] code);
    logic [2:0] r;
    r = 3'h3;
    case (code)
      `SCSC_SRC_EXT, `SCSC_SRC_EXT_PLL: r = 3'h4;
      `SCSC_SRC_SLOW: r = 3'h2;
      `SCSC_SRC_SEC: r = 3'h1;
      default: r = 3'h3;
    endcase
    return r;
  endfunction : osc_idx

  function automatic logic uses_pll(input logic [2:0] code);
    return code == `SCSC_SRC_FAST_PLL || code == `SCSC_SRC_EXT_PLL;
  endfunction : uses_pll

  logic [2:0] req_src;
  logic [2:0] cur_src;
  logic [4:0] osc_ready;
  logic pll_ready;
  logic [3:0] lock_cnt_q;
  logic req_path_ready;

  assign req_src = eff_src(req_q.src);
  assign cur_src = eff_src(cur_q.src);

  ////////////////////////////////////////////////////////////////////////////
  // oscillator enables and ready flags
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_osc
      assign osc_enable[gi] = force_q[gi] || osc_other_req[gi]
        || osc_idx(req_src) == 3'(gi) || osc_idx(cur_src) == 3'(gi);
      assign osc_ready[gi] = osc_enable[gi] && rdy_s2_q[gi];
    end
  endgenerate

  assign pll_enable = uses_pll(req_src) || uses_pll(cur_src);
  assign pll_input_sel = (sw_q != SCSC_IDLE && uses_pll(req_src)) ? req_src : cur_src;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_q <= 4'h0;
    end else if (!pll_enable || !rdy_s2_q[5]) begin
      lock_cnt_q <= 4'h0;
    end else if (lock_cnt_q != `SCSC_PLL_LOCK_CYC) begin
      lock_cnt_q <= lock_cnt_q + 4'h1;
    end
  end

  assign pll_ready = pll_enable && osc_ready[osc_idx(pll_input_sel)]
    && lock_cnt_q == `SCSC_PLL_LOCK_CYC;
  assign req_path_ready = osc_ready[osc_idx(req_src)] && (!uses_pll(req_src) || pll_ready);

  ////////////////////////////////////////////////////////////////////////////
  // switch sequencer
  assign target_rdy = sw_q != SCSC_IDLE && req_path_ready;
  assign do_switch = (sw_q == SCSC_WAIT && req_path_ready && !hold_q)
    || (sw_q == SCSC_HELD && !hold_q && req_path_ready);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q <= SCSC_IDLE;
    end else begin
      case (sw_q)
        SCSC_IDLE: begin
          if (fuse_taken_q && req_q != cur_q) begin
            sw_q <= SCSC_WAIT;
          end
        end
        SCSC_WAIT, SCSC_HELD: begin
          if (req_q == cur_q) begin
            sw_q <= SCSC_IDLE;
          end else if (do_switch) begin
            sw_q <= SCSC_IDLE;
          end else if (req_path_ready && hold_q) begin
            sw_q <= SCSC_HELD;
          end
        end
        default: sw_q <= SCSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trdy_q <= 1'b0;
    end else begin
      trdy_q <= target_rdy && !do_switch;
    end
  end

  // event flag: set wins over a same-cycle clear
  logic trdy_rise;
  assign trdy_rise = target_rdy && !trdy_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 1'b0;
    end else if (trdy_rise) begin
      evt_q <= 1'b1;
    end else if (wr_en && paddr == `SCSC_EVENT_ADDR && pwdata[0]) begin
      evt_q <= 1'b0;
    end
  end

  assign switch_event_flag = evt_q;
  assign switch_irq = evt_q && switch_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // pin and clock outputs
  logic src_tick;
  logic [4:0] tick_rise;

  assign tick_rise = tick_s2_q & ~tick_s3_q;
  assign src_tick = tick_rise[osc_idx(cur_src)];
  assign fast_internal_freq_sel = freq_q;
  assign fast_internal_trim = trim_q;
  assign sec_osc_high_power = !byp_q && pwr_q;
  assign sec_osc_in_schmitt = byp_q;
  assign sec_osc_out_enable = !byp_q && osc_enable[1];

  scsc_postdiv u_postdiv (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .ratio_log2(cur_q.div),
    .sys_tick(sys_clk_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb read
  logic [7:0] rd_byte;
  logic done;

  assign done = req_q == cur_q;

  always_comb begin
    rd_byte = 8'h00;
    case (paddr)
      `SCSC_REQ_SEL_ADDR: rd_byte = {1'b0, req_q.src, req_q.div};
      `SCSC_CUR_SEL_ADDR: rd_byte = {1'b0, cur_q.src, cur_q.div};
      `SCSC_SWITCH_ADDR: rd_byte = {hold_q, pwr_q, byp_q, done, trdy_q, 3'h0};
      `SCSC_READY_ADDR: rd_byte = {osc_ready[4:3], 1'b0, osc_ready[2:0], 1'b0, pll_ready};
      `SCSC_FORCE_ADDR: rd_byte = {force_q[4:3], 1'b0, force_q[2:0], 2'h0};
      `SCSC_FREQ_ADDR: rd_byte = {5'h00, freq_q};
      `SCSC_TRIM_ADDR: rd_byte = {2'h0, trim_q};
      `SCSC_EVENT_ADDR: rd_byte = {7'h00, evt_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  assign pready = psel && penable;
  assign pslverr = psel && penable && paddr > `SCSC_EVENT_ADDR;
endmodule : scsc_top

// file: test/scsc_checker.sv
`timescale 1ns/1ps
module scsc_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pslverr, // error
  input wire logic [2:0] reset_source_fuse, // fuse
  input wire logic [2:0] external_mode_fuse, // fuse
  input wire logic [2:0] ext_osc_mode, // mode
  input wire logic switch_event_flag, // event
  input wire logic switch_irq_enable, // irq enable
  input wire logic switch_irq, // irq
  input wire logic sec_osc_in_schmitt, // bypass input
  input wire logic sec_osc_out_enable, // crystal output
  input wire logic [2:0] fast_internal_freq_sel, // freq
  input wire logic [5:0] fast_internal_trim // trim
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable;
  ////////////////////////////////////////////////////////////
  property p_upper; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_slverr; acc |-> pslverr == (paddr > 12'h01C); endproperty
  a_slverr: assert property (p_slverr) else $error("bad error response");
  property p_mode; ext_osc_mode == external_mode_fuse; endproperty
  a_mode: assert property (p_mode) else $error("external mode not from fuse");
  property p_irq; switch_irq == (switch_event_flag && switch_irq_enable); endproperty
  a_irq: assert property (p_irq) else $error("switch request wrong");
  property p_byp; sec_osc_in_schmitt |-> !sec_osc_out_enable; endproperty
  a_byp: assert property (p_byp) else $error("output pin used in bypass");
  property p_frst;
    $past(presetn) && !$past(presetn, 2) |->
      fast_internal_freq_sel == (reset_source_fuse == 3'h0 ? 3'h6 : 3'h2);
  endproperty
  a_frst: assert property (p_frst) else $error("freq reset value wrong");
  property p_fwr;
    $changed(fast_internal_freq_sel) && $past(presetn, 2) |-> $past(acc && pwrite && paddr == 12'h014);
  endproperty
  a_fwr: assert property (p_fwr) else $error("freq changed without write");
  property p_twr;
    $changed(fast_internal_trim) && $past(presetn, 2) |-> $past(acc && pwrite && paddr == 12'h018);
  endproperty
  a_twr: assert property (p_twr) else $error("trim changed without write");
endmodule : scsc_checker

// file: test/scsc_top_test.sv
`timescale 1ns/1ps
module scsc_top_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [2:0] reset_source_fuse, external_mode_fuse, ext_osc_mode, fast_internal_freq_sel;
  logic [4:0] osc_tick_raw, osc_ready_raw, osc_other_req, osc_enable;
  logic [5:0] fast_internal_trim;
  logic switch_enable_fuse, pll_lock_raw, switch_irq_enable, switch_irq, switch_event_flag;
  logic sec_osc_high_power, sec_osc_in_schmitt, sec_osc_out_enable;
  logic sys_clk_en, pll_enable, count_en;
  logic [2:0] pll_input_sel;
  logic [4:0] tick_prev;
  logic [1:0] cnt_dly;
  int seed = 22980;
  int mismatches = 0;
  int compares = 0;
  int tick_rises = 0;
  int sys_pulses = 0;
  scsc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reset_source_fuse, .external_mode_fuse, .switch_enable_fuse, .osc_tick_raw,
    .osc_ready_raw, .pll_lock_raw, .osc_other_req, .switch_irq_enable, .osc_enable,
    .pll_enable, .pll_input_sel, .ext_osc_mode, .fast_internal_freq_sel, .fast_internal_trim,
    .sec_osc_high_power, .sec_osc_in_schmitt, .sec_osc_out_enable, .sys_clk_en,
    .switch_event_flag, .switch_irq);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    {osc_other_req, switch_irq_enable, osc_tick_raw} <= 11'($random(seed));
  end
  // source tick rises against system enable pulses, the latter two cycles later
  always @(posedge pclk) begin
    tick_prev <= osc_tick_raw;
    cnt_dly <= {cnt_dly[0], count_en};
    if (count_en && osc_tick_raw[3] && !tick_prev[3]) begin
      tick_rises++;
    end
    if (cnt_dly[1] && sys_clk_en) begin
      sys_pulses++;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] ready_byte(input logic [4:0] r, input logic p);
    return {24'h0, r[4:3], 1'b0, r[2:0], 1'b0, p};
  endfunction : ready_byte
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic wait_rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while ((rd & m) !== x && k < 100);
    if ((rd & m) !== x) begin
      mismatches++;
      close_out();
    end
  endtask : wait_rd
  ////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {osc_tick_raw, osc_ready_raw, osc_other_req, switch_irq_enable} = '0;
    count_en = 1'b0;
    presetn = 1'b0;
    reset_source_fuse = 3'h6;
    external_mode_fuse = 3'h5;
    switch_enable_fuse = 1'b1;
    pll_lock_raw = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdc(12'h000, 32'h62);
    rdc(12'h004, 32'h62);
    rdc(12'h008, 32'h10);
    rdc(12'h014, 32'h02);
    rdc(12'h018, 32'h00);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 32'h1);
    $display("done: reset values");
    for (int i = 0; i < 8; i++) begin
      v = 32'($random(seed));
      wr(12'h014, {v[31:3], 3'(i)});
      rdc(12'h014, {29'h0, 3'(i)});
      chk(fast_internal_freq_sel, i);
      wr(12'h018, v);
      rdc(12'h018, {26'h0, v[5:0]});
    end
    $display("done: frequency and trim");
    osc_ready_raw <= 5'h1F;
    wr(12'h008, 32'h00);
    wr(12'h000, 32'h73);
    wait_rd(12'h008, 32'h10, 32'h10);
    rdc(12'h004, 32'h73);
    rdc(12'h008, 32'h10);
    chk(switch_event_flag, 32'h1);
    rdc(12'h01C, 32'h1);
    wr(12'h01C, 32'h1);
    chk(switch_event_flag, 32'h0);
    $display("done: switch without hold");
    osc_ready_raw <= 5'h10;
    wr(12'h008, 32'h80);
    wr(12'h000, 32'h39);
    rdc(12'h008, 32'h80);
    osc_ready_raw <= 5'h1F;
    wait_rd(12'h008, 32'h08, 32'h08);
    rdc(12'h008, 32'h88);
    rdc(12'h004, 32'h73);
    chk(switch_event_flag, 32'h1);
    wr(12'h008, 32'h00);
    wait_rd(12'h008, 32'h10, 32'h10);
    rdc(12'h004, 32'h39);
    $display("done: held switch");
    wr(12'h000, 32'h3A);
    rdc(12'h000, 32'h39);
    wr(12'h004, 32'hFF);
    rdc(12'h004, 32'h39);
    wr(12'h008, 32'h67);
    rdc(12'h008, 32'h70);
    chk(sec_osc_in_schmitt, 32'h1);
    chk(sec_osc_high_power, 32'h0);
    wr(12'h008, 32'h40);
    chk(sec_osc_high_power, 32'h1);
    chk(sec_osc_out_enable, 32'h1);
    chk(sec_osc_in_schmitt, 32'h0);
    wr(12'h008, 32'h00);
    chk(sec_osc_high_power, 32'h0);
    $display("done: divider and secondary");
    wr(12'h010, 32'hFF);
    rdc(12'h010, 32'hDC);
    chk(osc_enable, 32'h1F);
    for (int i = 0; i < 4; i++) begin
      v = 32'($random(seed));
      osc_ready_raw <= v[4:0];
      repeat (4) @(posedge pclk);
      rdc(12'h00C, ready_byte(v[4:0], 1'b0));
    end
    $display("done: ready status");
    osc_ready_raw <= 5'h1F;
    presetn <= 1'b0;
    reset_source_fuse <= 3'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdc(12'h014, 32'h06);
    rdc(12'h000, 32'h00);
    rdc(12'h004, 32'h00);
    chk(pll_enable, 32'h1);
    chk(pll_input_sel, 32'h0);
    wait_rd(12'h00C, 32'h41, 32'h41);
    chk(rd & 32'h41, 32'h41);
    pll_lock_raw <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd & 32'h01, 32'h0);
    $display("done: pll source after reset");
    wr(12'h000, 32'h50);
    wait_rd(12'h008, 32'h10, 32'h10);
    rdc(12'h004, 32'h50);
    chk(pll_enable, 32'h0);
    chk(pll_input_sel, 32'h6);
    count_en <= 1'b1;
    repeat (200) @(posedge pclk);
    count_en <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(sys_pulses, tick_rises);
    chk(32'(tick_rises > 10), 32'h1);
    $display("done: reserved source and system clock");
    close_out();
  end
endmodule : scsc_top_test

bind scsc_top scsc_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pslverr, .reset_source_fuse, .external_mode_fuse, .ext_osc_mode, .switch_event_flag,
  .switch_irq_enable, .switch_irq, .sec_osc_in_schmitt, .sec_osc_out_enable,
  .fast_internal_freq_sel, .fast_internal_trim);
